// ### dcpr_pkg.sv
/*
  Package for the converter configuration slice: register indices, field
  positions, reset values and the packed control type.
  Assumes a 32-bit AXI4-Lite register bus, one aligned word per register.
*/
`default_nettype none
package dcpr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] DCPR_IDX_FIRST_CFG = 6'h01;
  localparam logic [5:0] DCPR_IDX_CTRL_LOW = 6'h02;
  localparam logic [5:0] DCPR_IDX_SCALE_TX = 6'h03;
  localparam logic [5:0] DCPR_IDX_FAIL_FLAGS = 6'h04;
  localparam logic [5:0] DCPR_IDX_IRQ_STATUS = 6'h10;
  localparam logic [5:0] DCPR_IDX_IRQ_MASK = 6'h11;
  localparam logic [5:0] DCPR_IDX_PATTERN_BASE = 6'h18;

  // Field positions
  localparam int DCPR_BIT_CHECK_ENA = 15;
  localparam int DCPR_BIT_FOUR_WIRE = 7;
  localparam int DCPR_BIT_MIXER_ENA = 6;
  localparam int DCPR_BIT_MIXER_GAIN = 5;
  localparam int DCPR_BIT_NCO_ENA = 4;
  localparam int DCPR_BIT_REVBUS = 3;
  localparam int DCPR_BIT_TWOS = 1;
  localparam int DCPR_BIT_SCALE_LSB = 12;
  localparam int DCPR_BIT_SW_TXEN = 0;
  localparam int DCPR_BIT_IRQ_MISMATCH = 0;

  // Reset values
  localparam logic [15:0] DCPR_RST_SCALE_TX = 16'hF000;
  localparam logic [3:0] DCPR_RST_SCALE = 4'hF;
  localparam logic [7:0] DCPR_RST_CTRL_LOW = 8'h00;

  // Bus answers
  localparam logic [1:0] DCPR_RESP_OKAY = 2'h0;
  localparam logic [1:0] DCPR_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic four_wire_port_select;
    logic mixer_enable;
    logic mixer_gain_boost;
    logic nco_enable;
    logic bus_reverse;
    logic rsv2;
    logic twos_complement;
    logic rsv0;
  } dcpr_ctrl_low_t;

endpackage
`default_nettype wire

// ### dcpr_regs.sv
/*
  Configuration register slice of a multi-channel converter: control low
  byte, full-scale/transmit word, sticky pattern failure flags, a pattern
  checker and an interrupt. Assumes an AXI4-Lite master on REF_CLK and
  input samples synchronous to REF_CLK.
*/
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Control bit 7 set selects four-wire configuration port, clear selects three-wire.
// - Mixing stage enabled only while control bit 6 is set; off at reset.
// - Control bit 5 adds 6dB gain after the mixing stage.
// - Bit 4 enables the oscillator; coarse mixing works without it.
// - Control bit 3 reverses captured input bus bit order.
// - Control bit 1 selects two's complement input, else offset binary.
// - Bits 15:12, reset 1111, set full-scale current as code plus one.
// - Output control word at 0x03 resets to 0xF000; bits 11:1 reserved zero.
// - Internal transmit enable is software bit 0 OR the external pin.
// - Failure word meaningful only while pattern checking is enabled.
// - Each failure bit flags the matching input data line; with control bit 3 set, bit n flags line 15-n.
// - Failure word has no reset value; host write clears it.
// - Checker compares captured words with expected pattern words, alarming on mismatch.
module dcpr_regs
  import dcpr_pkg::*;
#(
  parameter int PATTERN_DEPTH = 8,
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Input sample bus
  input wire logic [15:0] DATA_IN,
  input wire logic DATA_VALID,
  // External transmit enable pin
  input wire logic TXENABLE_PIN,
  // Datapath controls
  output logic FOUR_WIRE_PORT_SELECT,
  output logic MIXER_ENABLE,
  output logic MIXER_GAIN_BOOST,
  output logic NCO_ENABLE,
  output logic [3:0] FULL_SCALE_CODE,
  output logic TX_ENABLE,
  // Conditioned sample, offset binary
  output logic [15:0] SAMPLE_OUT,
  output logic SAMPLE_VALID,
  output logic PATTERN_ALARM,
  // Interrupt
  output logic IRQ
);

  localparam int PTR_W = (PATTERN_DEPTH > 1) ? $clog2(PATTERN_DEPTH) : 1;

  initial begin
    if (PATTERN_DEPTH < 1 || PATTERN_DEPTH > 8) begin
      $error("PATTERN_DEPTH must be 1 to 8");
    end
    if (ADDR_W < 8) begin
      $error("ADDR_W must be at least 8");
    end
  end

  // Register state
  dcpr_ctrl_low_t ctrl_q;
  logic [3:0] scale_q;
  logic sw_txen_q;
  logic check_ena_q;
  logic [15:0] flags_q;
  logic [15:0] flags_d;
  logic irq_status_q;
  logic irq_mask_q;
  logic [15:0] pat_q [PATTERN_DEPTH];
  logic [PTR_W-1:0] ptr_q;

  // Bus state
  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic awready_q;
  logic wready_q;
  logic arready_q;

  // Handshakes
  wire aw_take = S_AXI_AWVALID & awready_q;
  wire w_take = S_AXI_WVALID & wready_q;
  wire ar_take = S_AXI_ARVALID & arready_q;
  wire do_write = aw_full_q & w_full_q & ~bvalid_q;
  wire b_done = bvalid_q & S_AXI_BREADY;
  wire r_done = rvalid_q & S_AXI_RREADY;

  wire aw_full_d = (aw_full_q | aw_take) & ~do_write;
  wire w_full_d = (w_full_q | w_take) & ~do_write;
  wire bvalid_d = (bvalid_q & ~b_done) | do_write;
  wire rvalid_d = (rvalid_q & ~r_done) | ar_take;

  // Write decode
  wire [5:0] wr_idx = aw_addr_q[7:2];
  wire wr_hi_ok = (aw_addr_q[ADDR_W-1:2] >> 6) == '0;
  wire wr_first = do_write & wr_hi_ok & (wr_idx == DCPR_IDX_FIRST_CFG);
  wire wr_ctrl = do_write & wr_hi_ok & (wr_idx == DCPR_IDX_CTRL_LOW);
  wire wr_scale = do_write & wr_hi_ok & (wr_idx == DCPR_IDX_SCALE_TX);
  wire wr_flags = do_write & wr_hi_ok & (wr_idx == DCPR_IDX_FAIL_FLAGS);
  wire wr_istat = do_write & wr_hi_ok & (wr_idx == DCPR_IDX_IRQ_STATUS);
  wire wr_imask = do_write & wr_hi_ok & (wr_idx == DCPR_IDX_IRQ_MASK);
  wire [5:0] wr_pat_off = wr_idx - DCPR_IDX_PATTERN_BASE;
  wire wr_pat = do_write & wr_hi_ok & (wr_idx >= DCPR_IDX_PATTERN_BASE) &
                (32'(wr_pat_off) < PATTERN_DEPTH);
  wire wr_mapped = wr_first | wr_ctrl | wr_scale | wr_flags | wr_istat | wr_imask | wr_pat;
  wire [15:0] wr_mask16 = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  // Read decode
  wire [5:0] rd_idx = S_AXI_ARADDR[7:2];
  wire rd_hi_ok = (S_AXI_ARADDR[ADDR_W-1:2] >> 6) == '0;
  wire [5:0] rd_pat_off = rd_idx - DCPR_IDX_PATTERN_BASE;
  wire rd_pat = rd_hi_ok & (rd_idx >= DCPR_IDX_PATTERN_BASE) & (32'(rd_pat_off) < PATTERN_DEPTH);
  wire [PTR_W-1:0] rd_pat_sel = rd_pat_off[PTR_W-1:0];
  wire [15:0] rd_first = 16'(check_ena_q) << DCPR_BIT_CHECK_ENA;
  wire [15:0] rd_ctrl = {8'h00, ctrl_q.four_wire_port_select, ctrl_q.mixer_enable,
                         ctrl_q.mixer_gain_boost, ctrl_q.nco_enable, ctrl_q.bus_reverse,
                         1'b0, ctrl_q.twos_complement, 1'b0};
  wire [15:0] rd_scale = {scale_q, 11'h000, sw_txen_q};
  wire rd_first_hit = rd_hi_ok & (rd_idx == DCPR_IDX_FIRST_CFG);
  wire rd_ctrl_hit = rd_hi_ok & (rd_idx == DCPR_IDX_CTRL_LOW);
  wire rd_scale_hit = rd_hi_ok & (rd_idx == DCPR_IDX_SCALE_TX);
  wire rd_flags_hit = rd_hi_ok & (rd_idx == DCPR_IDX_FAIL_FLAGS);
  wire rd_istat_hit = rd_hi_ok & (rd_idx == DCPR_IDX_IRQ_STATUS);
  wire rd_imask_hit = rd_hi_ok & (rd_idx == DCPR_IDX_IRQ_MASK);
  wire rd_mapped = rd_first_hit | rd_ctrl_hit | rd_scale_hit | rd_flags_hit |
                   rd_istat_hit | rd_imask_hit | rd_pat;
  wire [15:0] rd_val = rd_first_hit ? rd_first :
                       rd_ctrl_hit ? rd_ctrl :
                       rd_scale_hit ? rd_scale :
                       rd_flags_hit ? flags_q :
                       rd_istat_hit ? 16'(irq_status_q) :
                       rd_imask_hit ? 16'(irq_mask_q) :
                       rd_pat ? pat_q[rd_pat_sel] : 16'h0000;

  // bit reversal of the captured bus
  logic [15:0] data_rev;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_rev
      assign data_rev[gi] = DATA_IN[15-gi];
    end
  endgenerate
  wire [15:0] data_cap = ctrl_q.bus_reverse ? data_rev : DATA_IN;

  // compare captured word with expected pattern
  wire check_now = check_ena_q & DATA_VALID;
  wire [15:0] mismatch = check_now ? (data_cap ^ pat_q[ptr_q]) : 16'h0000;
  wire any_mismatch = |mismatch;
  wire [PTR_W-1:0] ptr_next = (32'(ptr_q) == PATTERN_DEPTH - 1) ? '0 : PTR_W'(ptr_q + 1'b1);

  // set wins over the host clear
  // bit n follows data line n, or line 15-n while bus reversal is on
  assign flags_d = (flags_q & ~(wr_flags ? (w_data_q[15:0] & wr_mask16) : 16'h0000)) | mismatch;

  // Bus handshake registers
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q <= ~w_full_d & ~bvalid_d;
      arready_q <= ~rvalid_d;
    end
  end

  // Bus payload registers
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_addr_q <= '0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bresp_q <= DCPR_RESP_OKAY;
      rdata_q <= 32'h00000000;
      rresp_q <= DCPR_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (w_take) begin
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (do_write) begin
        bresp_q <= wr_mapped ? DCPR_RESP_OKAY : DCPR_RESP_SLVERR;
      end
      if (ar_take) begin
        rdata_q <= {16'h0000, rd_val};
        rresp_q <= rd_mapped ? DCPR_RESP_OKAY : DCPR_RESP_SLVERR;
      end
    end
  end

  // Software registers
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= DCPR_RST_CTRL_LOW;
      scale_q <= DCPR_RST_SCALE_TX[15:12];
      sw_txen_q <= DCPR_RST_SCALE_TX[DCPR_BIT_SW_TXEN];
      check_ena_q <= 1'b0;
      irq_mask_q <= 1'b0;
    end else begin
      if (wr_ctrl & w_strb_q[0]) begin
        ctrl_q <= dcpr_ctrl_low_t'(w_data_q[7:0] & 8'hFA);
      end
      if (wr_scale & w_strb_q[1]) begin
        scale_q <= w_data_q[DCPR_BIT_SCALE_LSB +: 4];
      end
      if (wr_scale & w_strb_q[0]) begin
        sw_txen_q <= w_data_q[DCPR_BIT_SW_TXEN];
      end
      if (wr_first & w_strb_q[1]) begin
        check_ena_q <= w_data_q[DCPR_BIT_CHECK_ENA];
      end
      if (wr_imask & w_strb_q[0]) begin
        irq_mask_q <= w_data_q[DCPR_BIT_IRQ_MISMATCH];
      end
    end
  end

  // Expected pattern words
  generate
    for (gi = 0; gi < PATTERN_DEPTH; gi++) begin : g_pat
      always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          pat_q[gi] <= 16'h0000;
        end else if (wr_pat && (32'(wr_pat_off) == gi)) begin
          pat_q[gi] <= (pat_q[gi] & ~wr_mask16) | (w_data_q[15:0] & wr_mask16);
        end
      end
    end
  endgenerate

  // no reset; cleared only by host write
  // only set while checking is enabled
  always_ff @(posedge REF_CLK) begin
    flags_q <= flags_d;
  end

  // Checker pointer and interrupt status
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ptr_q <= '0;
      irq_status_q <= 1'b0;
    end else begin
      // Restart from the first word whenever checking is off
      if (!check_ena_q) begin
        ptr_q <= '0;
      end else if (DATA_VALID) begin
        ptr_q <= ptr_next;
      end
      irq_status_q <= any_mismatch |
                      (irq_status_q & ~(wr_istat & w_strb_q[0] & w_data_q[DCPR_BIT_IRQ_MISMATCH]));
    end
  end

  // Registered outputs
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      FOUR_WIRE_PORT_SELECT <= 1'b0;
      MIXER_ENABLE <= 1'b0;
      MIXER_GAIN_BOOST <= 1'b0;
      NCO_ENABLE <= 1'b0;
      FULL_SCALE_CODE <= DCPR_RST_SCALE;
      TX_ENABLE <= 1'b0;
      SAMPLE_OUT <= 16'h0000;
      SAMPLE_VALID <= 1'b0;
      PATTERN_ALARM <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      FOUR_WIRE_PORT_SELECT <= ctrl_q.four_wire_port_select;
      MIXER_ENABLE <= ctrl_q.mixer_enable;
      MIXER_GAIN_BOOST <= ctrl_q.mixer_gain_boost;
      NCO_ENABLE <= ctrl_q.nco_enable;
      // current proportional to code plus one
      FULL_SCALE_CODE <= scale_q;
      // both low needed to stop output
      TX_ENABLE <= sw_txen_q | TXENABLE_PIN;
      // flip sign bit to reach offset binary
      SAMPLE_OUT <= {data_cap[15] ^ ctrl_q.twos_complement, data_cap[14:0]};
      SAMPLE_VALID <= DATA_VALID;
      PATTERN_ALARM <= any_mismatch;
      IRQ <= (irq_status_q | any_mismatch) & irq_mask_q;
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

  // Protection bits carry no meaning here
  wire unused_prot = ^{S_AXI_AWPROT, S_AXI_ARPROT, w_data_q[31:16], w_strb_q[3:2]};

endmodule
`default_nettype wire

// ### dcpr_regs_asserts.sv
/*
  Port-level assertions for the converter configuration slice.
  Assumes binding onto dcpr_regs from the bench top file.
*/
`timescale 1ns/10ps
`default_nettype none
module dcpr_regs_chk (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // Register bus
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  // Samples and controls
  input wire logic DATA_VALID,
  input wire logic TXENABLE_PIN,
  input wire logic TX_ENABLE,
  input wire logic SAMPLE_VALID,
  input wire logic PATTERN_ALARM
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  sequence wr_take;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence rd_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  write_answer_a: assert property (wr_take |-> ##[1:2] S_AXI_BVALID) else $error("write answer missing");
  write_busy_a: assert property (wr_take |=> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("write ready not dropped");
  read_answer_a: assert property (rd_take |=> S_AXI_RVALID) else $error("read answer missing");
  read_busy_a: assert property (rd_take |=> !S_AXI_ARREADY) else $error("read ready not dropped");
  rdata_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  tx_pin_a: assert property (TXENABLE_PIN |=> TX_ENABLE)
    else $error("pin did not enable transmit");
  sample_valid_a: assert property (1'b1 |=> SAMPLE_VALID == $past(DATA_VALID))
    else $error("sample valid not one cycle late");
  alarm_cause_a: assert property (PATTERN_ALARM |-> SAMPLE_VALID && $past(DATA_VALID))
    else $error("alarm without a checked sample");
endmodule
`default_nettype wire

// ### dcpr_regs_tb_top.sv
/*
  Self-checking bench for the converter configuration slice.
  Assumes dcpr_regs, its package, checker and sample source model.
*/
`timescale 1ns/10ps
`default_nettype none
module dcpr_regs_tb_top;
  import dcpr_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [2:0] prot = 3'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tx_pin, dvalid;
  logic four_w, mix, gain, nco, tx_en, s_valid, alarm, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] din, s_out;
  logic [3:0] fs_code;
  int error_cnt = 0;
  int n_tests = 0;

  dcpr_regs i_dcpr_regs (.REF_CLK(ref_clk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(prot),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(prot), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .DATA_IN(din), .DATA_VALID(dvalid), .TXENABLE_PIN(tx_pin),
    .FOUR_WIRE_PORT_SELECT(four_w), .MIXER_ENABLE(mix), .MIXER_GAIN_BOOST(gain), .NCO_ENABLE(nco),
    .FULL_SCALE_CODE(fs_code), .TX_ENABLE(tx_en), .SAMPLE_OUT(s_out), .SAMPLE_VALID(s_valid),
    .PATTERN_ALARM(alarm), .IRQ(irq));
  dcpr_sample_src i_dcpr_sample_src (.clk(ref_clk), .data_in(din), .data_valid(dvalid), .tx_pin(tx_pin));

  initial forever #2.5 ref_clk = ~ref_clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge ref_clk);
      if (awready === 1'b1 && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("write response", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(nm, rdata, exp);
    chk("read response", {30'h0, rresp}, {30'h0, er});
  endtask

  task automatic t_reset;
    chk("scale code", {28'h0, fs_code}, 32'hF);
    rdc("scale word", 8'h0C, 32'h0000F000, DCPR_RESP_OKAY);
    rdc("control low", 8'h08, 32'h0, DCPR_RESP_OKAY);
    chk("tx enable", {31'h0, tx_en}, 32'h0);
    wr(8'h10, 32'h0000FFFF, DCPR_RESP_OKAY);
    rdc("flags", 8'h10, 32'h0, DCPR_RESP_OKAY);
  endtask

  task automatic t_ctrl;
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, 32'h80 >> i, DCPR_RESP_OKAY);
      // Outputs follow the register one edge after the answer
      #1;
      // Mixer alone runs without the oscillator
      chk("control outputs", {28'h0, four_w, mix, gain, nco}, 32'h8 >> i);
    end
    wr(8'h08, 32'h000000FF, DCPR_RESP_OKAY);
    rdc("control low", 8'h08, 32'h000000FA, DCPR_RESP_OKAY);
  endtask

  task automatic t_scale;
    wr(8'h0C, 32'h00005FFF, DCPR_RESP_OKAY);
    rdc("scale word", 8'h0C, 32'h00005001, DCPR_RESP_OKAY);
    chk("scale code", {28'h0, fs_code}, 32'h5);
    chk("tx enable", {31'h0, tx_en}, 32'h1);
    // Low lane only: the code in the high byte must survive
    wstrb <= 4'h1;
    wr(8'h0C, 32'h0, DCPR_RESP_OKAY);
    wstrb <= 4'hF;
    repeat (2) @(posedge ref_clk);
    chk("scale kept", {28'h0, fs_code}, 32'h5);
    chk("tx stopped", {31'h0, tx_en}, 32'h0);
    i_dcpr_sample_src.set_pin(1'b1);
    repeat (2) @(posedge ref_clk);
    chk("tx by pin", {31'h0, tx_en}, 32'h1);
    i_dcpr_sample_src.set_pin(1'b0);
    wr(8'h80, 32'h1, DCPR_RESP_SLVERR);
    rdc("unmapped", 8'h80, 32'h0, DCPR_RESP_SLVERR);
  endtask

  task automatic t_sample;
    logic [15:0] exp [4];
    exp = '{16'h0001, 16'h8001, 16'h8000, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, (i & 1) << 1 | (i & 2) << 2, DCPR_RESP_OKAY);
      i_dcpr_sample_src.send(16'h0001);
      #1;
      chk("sample out", {16'h0, s_out}, {16'h0, exp[i]});
      chk("sample valid", {31'h0, s_valid}, 32'h1);
    end
    wr(8'h08, 32'h0, DCPR_RESP_OKAY);
  endtask

  task automatic t_pattern;
    i_dcpr_sample_src.send(16'h00F3);
    rdc("flags idle", 8'h10, 32'h0, DCPR_RESP_OKAY);
    wr(8'h60, 32'h000000F0, DCPR_RESP_OKAY);
    wr(8'h44, 32'h1, DCPR_RESP_OKAY);
    wr(8'h04, 32'h00008000, DCPR_RESP_OKAY);
    i_dcpr_sample_src.send(16'h00F3);
    #1;
    chk("alarm", {31'h0, alarm}, 32'h1);
    rdc("flags", 8'h10, 32'h00000003, DCPR_RESP_OKAY);
    i_dcpr_sample_src.send(16'h0000);
    rdc("flags sticky", 8'h10, 32'h00000003, DCPR_RESP_OKAY);
    wr(8'h10, 32'h1, DCPR_RESP_OKAY);
    rdc("flags cleared", 8'h10, 32'h00000002, DCPR_RESP_OKAY);
    rdc("irq status", 8'h40, 32'h1, DCPR_RESP_OKAY);
    chk("irq raised", {31'h0, irq}, 32'h1);
    wr(8'h44, 32'h0, DCPR_RESP_OKAY);
    @(posedge ref_clk);
    #1;
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(8'h44, 32'h1, DCPR_RESP_OKAY);
    wr(8'h40, 32'h1, DCPR_RESP_OKAY);
    @(posedge ref_clk);
    #1;
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask

  task automatic print_verdict;
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_reset();
    t_ctrl();
    t_scale();
    t_sample();
    t_pattern();
    print_verdict();
  end

  // Whole run needs under two hundred cycles
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
endmodule

bind dcpr_regs dcpr_regs_chk i_dcpr_regs_chk (.REF_CLK, .ARST_N, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
  .S_AXI_RVALID, .DATA_VALID, .TXENABLE_PIN, .TX_ENABLE, .SAMPLE_VALID, .PATTERN_ALARM);
`default_nettype wire

// ### dcpr_sample_src.sv
/*
  Far-side model: sample source and external transmit pin.
  Assumes its tasks are called just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module dcpr_sample_src (
  // Clock
  input wire logic clk,
  // Sample bus and pin
  output var logic [15:0] data_in,
  output var logic data_valid,
  output var logic tx_pin
);
  initial begin
    data_in = 16'h0000;
    data_valid = 1'b0;
    tx_pin = 1'b0;
  end
  // Idle bus shows the inverse word, never stale data
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    data_in <= w;
    data_valid <= 1'b1;
    @(posedge clk);
    data_valid <= 1'b0;
    data_in <= ~w;
  endtask
  task automatic set_pin(input logic v);
    @(posedge clk);
    tx_pin <= v;
  endtask
endmodule
`default_nettype wire
